// ### src/lsti_pkg.sv
package lsti_pkg;
    // register offsets
    localparam logic [7:0] OFS_LOW_LO   = 8'h84;
    localparam logic [7:0] OFS_LOW_HI   = 8'h85;
    localparam logic [7:0] OFS_HIGH_LO  = 8'h86;
    localparam logic [7:0] OFS_HIGH_HI  = 8'h87;
    localparam logic [7:0] OFS_PERSIST  = 8'h8C;
    localparam logic [7:0] OFS_CONFIG   = 8'h8D;
    localparam logic [7:0] OFS_GAIN     = 8'h8F;
    localparam logic [7:0] OFS_AUX      = 8'h90;
    localparam logic [7:0] OFS_REVISION = 8'h91;
    localparam logic [7:0] OFS_FORCE    = 8'hE4;
    localparam logic [7:0] OFS_CLR_CHAN = 8'hE6;
    localparam logic [7:0] OFS_CLR_ALL  = 8'hE7;
    // field positions
    localparam int PERSIST_MSB   = 3;
    localparam int CFG_FIXED_BIT = 6;
    localparam int CFG_WAIT_LONG_BIT = 1;
    localparam int GAIN_MSB      = 1;
    localparam int AUX_SATEN_BIT = 5;
    localparam int REV_MSB       = 3;
    // reset values
    localparam logic [7:0] CONFIG_RESET = 8'h40;
    localparam logic [7:0] REG_RESET    = 8'h00;
    // arbitrary die revision value, not tied to any real part
    localparam logic [3:0] DIE_REV_DEFAULT = 4'h1;
    // persistence figures
    localparam logic [5:0] PERSIST_MAX  = 6'h3C;
    localparam logic [5:0] PERSIST_STEP = 6'h05;
    // wait timing
    localparam int WAIT_STEP_NS   = 2_780_000;
    localparam int CLK_PERIOD_NS  = 5;
    localparam int WAIT_STEP_CYC  = WAIT_STEP_NS / CLK_PERIOD_NS;
    localparam logic [3:0] WAIT_LONG_MULT = 4'hC;
    localparam logic [8:0] WAIT_MOD       = 9'h100;

    // one conversion result handed over by the converter
    typedef struct packed {
        logic        done;      // one-cycle end of conversion
        logic        saturated; // sensor at top of range
        logic [15:0] result;    // clear channel result
    } lsti_sample_t;

    // consecutive out-of-window count a persistence code needs
    function automatic logic [5:0] lsti_need(input logic [3:0] code);
        logic [5:0] c;
        c = {2'b00, code};
        if (code <= 4'h3) begin
            lsti_need = c;
        end else begin
            lsti_need = 6'((c - 6'h03) * PERSIST_STEP);
        end
    endfunction

    // result outside inclusive low..high window
    function automatic logic lsti_outside(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        lsti_outside = (v < lo) || (v > hi);
    endfunction

    // gain multiplier for the two-bit select
    function automatic logic [6:0] lsti_gain(input logic [1:0] sel);
        lsti_gain = 7'h01 << {sel, 1'b0};
    endfunction
endpackage

// ### src/lsti_persist.sv
`timescale 1ns/1ps
module lsti_persist (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       sample,
    input  wire logic       outside,
    input  wire logic [3:0] code,
    input  wire logic       restart,
    output logic            hit,
    output logic [5:0]      count
);
    import lsti_pkg::*;

    logic [5:0] count_reg;  // consecutive out-of-window samples
    logic [5:0] count_next;

    // count including the current sample
    always_comb begin
        count_next = count_reg;
        if (outside && count_reg != PERSIST_MAX) begin
            count_next = count_reg + 6'h01;
        end
    end

    // code zero fires on every sample, otherwise once the need is reached
    always_comb begin
        hit = 1'b0;
        if (sample) begin
            if (code == 4'h0) begin
                hit = 1'b1;
            end else begin
                hit = outside && (count_next >= lsti_need(code));
            end
        end
    end

    // run counter, back to zero inside window or after a rewrite
    always_ff @(posedge ref_clk) begin
        if (!rstn || restart) begin
            count_reg <= 6'h00;
        end else if (sample) begin
            count_reg <= outside ? count_next : 6'h00;
        end
    end

    assign count = count_reg;

    chk_count_restart: assert property (@(posedge ref_clk) disable iff (!rstn)
        (restart || (sample && !outside)) |=> count_reg == 6'h00)
        else $error("persistence count did not restart");
    chk_count_step: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sample && outside && !restart && count_reg < PERSIST_MAX) |=> count_reg == $past(count_reg) + 6'h01)
        else $error("persistence count did not advance");
endmodule

// ### src/lsti_top.sv
// Functional notes
// - sixteen-bit low and high thresholds compared
// - interrupt when enabled and persistently out
// - threshold bytes at 0x84 through 0x87
// - code zero interrupts every conversion cycle
// - code one interrupts for any outside
// - codes two, three need two, three
// - higher codes need five to sixty
// - wait long stretches wait twelve times
// - configuration resets to 0x40
// - gain select gives 1, 4, 16, 64
// - auxiliary bit five gates saturation interrupt
// - saturation interrupt cleared at 0xE6/0xE7
// - revision read-only, low nibble, upper zero
// - clear locations clear, force location asserts
// - saturation flag set at top, cleared
// - wait steps 2.78 ms, two's complement count
// - threshold flag set only while converting
`timescale 1ns/1ps
module lsti_top #(
    parameter int        WAIT_STEP_CYCLES = lsti_pkg::WAIT_STEP_CYC,
    parameter logic [3:0] DIE_REVISION    = lsti_pkg::DIE_REV_DEFAULT
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // register port behind the serial interface
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [7:0]                 reg_rdata,
    // enable bits held in the enable register elsewhere
    input  wire logic                  converter_enable,
    input  wire logic                  threshold_irq_enable,
    // conversion results
    input  wire lsti_pkg::lsti_sample_t conv,
    // wait timer
    input  wire logic                  wait_start,
    input  wire logic [7:0]            wait_period,
    output logic                       wait_done,
    output logic                       wait_busy,
    // measurement controls
    output logic [1:0]                 analog_gain_select,
    output logic [6:0]                 gain_mult,
    output logic                       threshold_irq_flag,
    output logic                       saturation_flag,
    // open-drain interrupt pin
    input  wire logic                  irq_in,
    output logic                       irq_out,
    output logic                       irq_oe_n
);
    import lsti_pkg::*;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    logic [15:0] low_threshold_reg;   // low window edge
    logic [15:0] high_threshold_reg;  // high window edge
    logic [3:0]  persistence_reg;     // persistence field
    logic [7:0]  configuration_reg;   // fixed bit and wait long
    logic [1:0]  gain_reg;            // gain select field
    logic        sat_irq_en_reg;      // saturation interrupt enable
    logic        thr_flag_reg;        // threshold interrupt flag
    logic        sat_flag_reg;        // saturation flag
    logic        force_reg;           // forced interrupt
    logic [7:0]  rdata_reg;           // read answer
    logic [1:0]  gain_out_reg;        // gain select to front end
    logic [6:0]  gain_mult_reg;       // decoded gain
    logic        irq_oe_n_reg;        // pin drive enable, low drives
    logic        wait_done_reg;       // end of wait strobe

    logic wr_persist;   // persistence field rewrite
    logic wr_clr_chan;  // clear channel interrupt
    logic wr_clr_all;   // clear every interrupt
    logic wr_force;     // force an interrupt
    logic sample;       // conversion counted by filter
    logic outside;      // result outside window
    logic thr_hit;      // filter criteria met
    logic [5:0] run_count;
    logic sat_set;      // saturation event
    logic irq_next;     // pin level wanted

    // write strobes for command locations
    assign wr_persist  = reg_wr && reg_addr == OFS_PERSIST;
    assign wr_clr_chan = reg_wr && reg_addr == OFS_CLR_CHAN;
    assign wr_clr_all  = reg_wr && reg_addr == OFS_CLR_ALL;
    assign wr_force    = reg_wr && reg_addr == OFS_FORCE;

    // threshold bytes
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            low_threshold_reg  <= {REG_RESET, REG_RESET};
            high_threshold_reg <= {REG_RESET, REG_RESET};
        end else if (reg_wr) begin
            unique case (reg_addr)
                OFS_LOW_LO:  low_threshold_reg[7:0]   <= reg_wdata;
                OFS_LOW_HI:  low_threshold_reg[15:8]  <= reg_wdata;
                OFS_HIGH_LO: high_threshold_reg[7:0]  <= reg_wdata;
                OFS_HIGH_HI: high_threshold_reg[15:8] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // control registers; reserved bits dropped
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            persistence_reg   <= REG_RESET[PERSIST_MSB:0];
            configuration_reg <= CONFIG_RESET;
            gain_reg          <= REG_RESET[GAIN_MSB:0];
            sat_irq_en_reg    <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == OFS_PERSIST) begin
                persistence_reg <= reg_wdata[PERSIST_MSB:0];
            end
            if (reg_addr == OFS_CONFIG) begin
                // host keeps the fixed bit at one
                configuration_reg <= reg_wdata & ((8'h01 << CFG_FIXED_BIT) | (8'h01 << CFG_WAIT_LONG_BIT));
            end
            if (reg_addr == OFS_GAIN) begin
                gain_reg <= reg_wdata[GAIN_MSB:0];
            end
            if (reg_addr == OFS_AUX) begin
                sat_irq_en_reg <= reg_wdata[AUX_SATEN_BIT];
            end
        end
    end

    // read mux, answer one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                OFS_LOW_LO:   rdata_reg <= low_threshold_reg[7:0];
                OFS_LOW_HI:   rdata_reg <= low_threshold_reg[15:8];
                OFS_HIGH_LO:  rdata_reg <= high_threshold_reg[7:0];
                OFS_HIGH_HI:  rdata_reg <= high_threshold_reg[15:8];
                OFS_PERSIST:  rdata_reg <= {4'h0, persistence_reg};
                OFS_CONFIG:   rdata_reg <= configuration_reg;
                OFS_GAIN:     rdata_reg <= {6'h00, gain_reg};
                OFS_AUX:      rdata_reg <= 8'(sat_irq_en_reg) << AUX_SATEN_BIT;
                OFS_REVISION: rdata_reg <= {4'h0, DIE_REVISION};
                default:      rdata_reg <= 8'h00;
            endcase
        end
    end

    // window compare and persistence filter
    assign sample  = conv.done && converter_enable;
    assign outside = lsti_outside(conv.result, low_threshold_reg, high_threshold_reg);

    lsti_persist u_persist (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .sample  (sample),
        .outside (outside),
        .code    (persistence_reg),
        .restart (wr_persist),
        .hit     (thr_hit),
        .count   (run_count)
    );

    // threshold flag: set wins over clear
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            thr_flag_reg <= 1'b0;
        end else if (thr_hit) begin
            thr_flag_reg <= 1'b1;
        end else if (wr_clr_chan || wr_clr_all) begin
            thr_flag_reg <= 1'b0;
        end
    end

    // saturation flag from the converter
    assign sat_set = conv.done && conv.saturated && converter_enable;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sat_flag_reg <= 1'b0;
        end else if (sat_set) begin
            sat_flag_reg <= 1'b1;
        end else if (wr_clr_chan || wr_clr_all || !converter_enable) begin
            sat_flag_reg <= 1'b0;
        end
    end

    // forced interrupt, dropped only by clear all
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            force_reg <= 1'b0;
        end else if (wr_force) begin
            force_reg <= 1'b1;
        end else if (wr_clr_all) begin
            force_reg <= 1'b0;
        end
    end

    // pin level: latched flags gated by their enables, force ungated
    assign irq_next = (thr_flag_reg && threshold_irq_enable)
                    || (sat_flag_reg && sat_irq_en_reg)
                    || force_reg;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq_oe_n_reg <= 1'b1;
        end else begin
            irq_oe_n_reg <= !irq_next;
        end
    end

    // gain outputs to the front end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            gain_out_reg  <= 2'b00;
            gain_mult_reg <= 7'h01;
        end else begin
            gain_out_reg  <= gain_reg;
            gain_mult_reg <= lsti_gain(gain_reg);
        end
    end

    // wait timer
    typedef enum logic {WT_IDLE, WT_RUN} lsti_wait_state_t;
    localparam int STEP_W = $clog2(WAIT_STEP_CYCLES + 1);

    lsti_wait_state_t wait_state_reg;
    logic [STEP_W-1:0] step_cnt_reg;  // cycles inside one step
    logic [11:0]       steps_left_reg; // steps still to run
    logic [11:0]       steps_next;     // steps for a new start
    logic              step_end;

    // two's complement period, stretched by wait long
    always_comb begin
        steps_next = 12'(WAIT_MOD - {1'b0, wait_period});
        if (configuration_reg[CFG_WAIT_LONG_BIT]) begin
            steps_next = 12'(steps_next * WAIT_LONG_MULT);
        end
    end

    assign step_end = step_cnt_reg == STEP_W'(WAIT_STEP_CYCLES - 1);

    // step counting and completion strobe
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wait_state_reg <= WT_IDLE;
            step_cnt_reg   <= '0;
            steps_left_reg <= 12'h000;
            wait_done_reg  <= 1'b0;
        end else begin
            wait_done_reg <= 1'b0;
            unique case (wait_state_reg)
                WT_IDLE: begin
                    if (wait_start) begin
                        wait_state_reg <= WT_RUN;
                        step_cnt_reg   <= '0;
                        steps_left_reg <= steps_next;
                    end
                end
                WT_RUN: begin
                    if (step_end) begin
                        step_cnt_reg <= '0;
                        if (steps_left_reg == 12'h001) begin
                            wait_state_reg <= WT_IDLE;
                            wait_done_reg  <= 1'b1;
                        end
                        steps_left_reg <= steps_left_reg - 12'h001;
                    end else begin
                        step_cnt_reg <= step_cnt_reg + STEP_W'(1);
                    end
                end
            endcase
        end
    end

    // outputs straight from flops; pin only ever pulls low
    assign reg_rdata          = rdata_reg;
    assign analog_gain_select = gain_out_reg;
    assign gain_mult          = gain_mult_reg;
    assign threshold_irq_flag = thr_flag_reg;
    assign saturation_flag    = sat_flag_reg;
    assign irq_oe_n           = irq_oe_n_reg;
    assign irq_out            = 1'b0;
    assign wait_done          = wait_done_reg;
    assign wait_busy          = wait_state_reg == WT_RUN;

    // steps of a conversion that fire the threshold interrupt
    sequence s_fire;
        sample && threshold_irq_enable && thr_hit;
    endsequence
    sequence s_pin_low;
        !irq_oe_n [*2];
    endsequence

    chk_every_cycle: assert property (
        (sample && persistence_reg == 4'h0) |=> thr_flag_reg)
        else $error("code zero did not set the flag");
    chk_single_out: assert property (
        (sample && persistence_reg == 4'h1 && outside) |=> thr_flag_reg)
        else $error("single outside sample missed");
    chk_inside_quiet: assert property (
        (sample && !outside && persistence_reg != 4'h0 && !thr_flag_reg) |=> !thr_flag_reg)
        else $error("flag set by an inside result");
    chk_fire_pin: assert property (
        s_fire ##1 (threshold_irq_enable && !wr_clr_chan && !wr_clr_all) |=> s_pin_low)
        else $error("interrupt pin not asserted");
    chk_need_count: assert property (
        (thr_hit && persistence_reg != 4'h0) |-> run_count + 6'h01 >= lsti_need(persistence_reg))
        else $error("interrupt before persistence met");
    chk_flag_holds: assert property (
        (thr_flag_reg && !wr_clr_chan && !wr_clr_all) |=> thr_flag_reg)
        else $error("threshold flag dropped without clear");
    chk_sat_clear: assert property (
        ((wr_clr_chan || wr_clr_all) && !sat_set) |=> !sat_flag_reg)
        else $error("saturation flag not cleared");
    chk_config_reset: assert property (
        $rose(rstn) |-> configuration_reg == CONFIG_RESET)
        else $error("configuration reset value wrong");
    chk_gain_decode: assert property (
        (reg_wr && reg_addr == OFS_GAIN) |=> ##1 gain_mult == lsti_gain($past(reg_wdata[1:0], 2)))
        else $error("gain decode wrong");
    chk_force_pin: assert property (
        wr_force |=> ##1 !irq_oe_n)
        else $error("force did not assert pin");
    chk_revision_ro: assert property (
        (reg_rd && reg_addr == OFS_REVISION) |=> reg_rdata == {4'h0, DIE_REVISION})
        else $error("revision read wrong");
endmodule

// ### sim/lsti_host_model.sv
`timescale 1ns/1ps
// host side of the register port, driving strobes just after the clock edge
module lsti_host_model (
    input  wire logic       ref_clk,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    import lsti_pkg::*;

    // idle bus at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // one-cycle write, then scramble released lines
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~v;
    endtask

    // one-cycle read, answer taken after the sampling edge lands
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        v = reg_rdata;
    endtask

    // configuration always written with bit six set, other reserved bits zero
    task automatic cfg(input logic wl);
        wr(OFS_CONFIG, {1'b0, 1'b1, 4'h0, wl, 1'b0});
    endtask
endmodule

// ### sim/test_lsti_top.sv
`timescale 1ns/1ps
module test_lsti_top;
    import lsti_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rstn    = 1'b0;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata;
    logic         reg_wr, reg_rd;
    logic         cen     = 1'b1;  // converter enable
    logic         ten     = 1'b1;  // threshold interrupt enable
    lsti_sample_t conv    = '0;    // conversion handed to the block
    logic         wstart  = 1'b0;
    logic [7:0]   wper    = 8'hFF;
    logic         wdone, wbusy, tflag, sflag, irq_o, irq_oe_n;
    logic [1:0]   gsel;
    logic [6:0]   gmult;
    wire          irq_pin = irq_oe_n;  // pulled up unless driven low
    int           error_cnt = 0;
    int           n_tests   = 0;
    logic [7:0]   d;

    lsti_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // short wait step keeps the timer tests quick
    lsti_top #(.WAIT_STEP_CYCLES(4)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .converter_enable(cen), .threshold_irq_enable(ten), .conv(conv), .wait_start(wstart),
        .wait_period(wper), .wait_done(wdone), .wait_busy(wbusy), .analog_gain_select(gsel),
        .gain_mult(gmult), .threshold_irq_flag(tflag), .saturation_flag(sflag),
        .irq_in(irq_pin), .irq_out(irq_o), .irq_oe_n(irq_oe_n));

    // clock at 200 MHz
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // compare and count
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // let flag and pin updates land
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    // one conversion result
    task automatic smp(input logic s, input logic [15:0] v);
        @(posedge ref_clk);
        conv <= '{1'b1, s, v};
        @(posedge ref_clk);
        conv.done <= 1'b0;
    endtask

    // reset values, read-only and unmapped places
    task automatic t_reset();
        host_u.rd(OFS_CONFIG, d);
        chk("config", d, CONFIG_RESET);
        host_u.wr(OFS_REVISION, 8'hFF);
        host_u.rd(OFS_REVISION, d);
        chk("revision", d, {4'h0, DIE_REV_DEFAULT});
        host_u.rd(8'h55, d);
        chk("unmapped", d, 8'h00);
        chk("pin idle", irq_pin, 1'b1);
        $display("test reset done");
    endtask

    // every gain code
    task automatic t_gain();
        for (int i = 0; i < 4; i++) begin
            host_u.wr(OFS_GAIN, 8'(i));
            settle();
            chk("gain sel", gsel, 16'(i));
            chk("gain mult", gmult, 16'(1 << (2 * i)));
        end
        $display("test gain done");
    endtask

    // window edges, run restart, sticky pin, clear
    task automatic t_window();
        logic [7:0] th [4];
        th = '{8'h00, 8'h01, 8'h00, 8'h02};
        for (int i = 0; i < 4; i++) begin
            host_u.wr(OFS_LOW_LO + 8'(i), th[i]);
            host_u.rd(OFS_LOW_LO + 8'(i), d);
            chk("threshold byte", d, th[i]);
        end
        host_u.wr(OFS_PERSIST, 8'h02);
        smp(1'b0, 16'h00FF);
        smp(1'b0, 16'h0100);
        smp(1'b0, 16'h0200);
        smp(1'b0, 16'h0201);
        settle();
        chk("run restart", tflag, 1'b0);
        smp(1'b0, 16'h0201);
        settle();
        chk("window flag", tflag, 1'b1);
        chk("window pin", irq_pin, 1'b0);
        smp(1'b0, 16'h0150);
        settle();
        chk("pin holds", irq_pin, 1'b0);
        host_u.wr(OFS_CLR_CHAN, 8'h00);
        settle();
        chk("cleared", {tflag, irq_pin}, 2'b01);
        host_u.wr(OFS_PERSIST, 8'h03);
        smp(1'b0, 16'h0000);
        smp(1'b0, 16'h0000);
        host_u.wr(OFS_PERSIST, 8'h03);
        smp(1'b0, 16'h0000);
        settle();
        chk("rewrite restart", tflag, 1'b0);
        host_u.wr(OFS_PERSIST, 8'h01);
        ten <= 1'b0;
        smp(1'b0, 16'hFFFF);
        settle();
        chk("gated pin", {tflag, irq_pin}, 2'b11);
        host_u.wr(OFS_CLR_ALL, 8'h00);
        ten <= 1'b1;
        settle();
        $display("test window done");
    endtask

    // one persistence code: one sample short, then the hit
    task automatic run(input logic [3:0] c);
        int need;
        need = (c <= 3) ? int'(c) : 5 * (int'(c) - 3);
        host_u.wr(OFS_PERSIST, {4'h0, c});
        repeat (need - 1) smp(1'b0, 16'h0300);
        settle();
        chk("early flag", tflag, 1'b0);
        smp(1'b0, 16'h0300);
        settle();
        chk("run flag", tflag, 1'b1);
        host_u.wr(OFS_CLR_CHAN, 8'h00);
        settle();
    endtask

    // every persistence code
    task automatic t_codes();
        host_u.wr(OFS_PERSIST, 8'h00);
        smp(1'b0, 16'h0150);
        settle();
        chk("every cycle", tflag, 1'b1);
        host_u.wr(OFS_CLR_CHAN, 8'h00);
        for (int c = 1; c < 16; c++) begin
            run(4'(c));
        end
        $display("test codes done");
    endtask

    // saturation flag, its gate and its clears
    task automatic t_sat();
        host_u.wr(OFS_PERSIST, 8'h01);
        host_u.wr(OFS_AUX, 8'h00);
        smp(1'b1, 16'h0150);
        settle();
        chk("sat flag", {sflag, irq_pin}, 2'b11);
        host_u.wr(OFS_CLR_ALL, 8'h00);
        host_u.wr(OFS_AUX, 8'h20);
        host_u.rd(OFS_AUX, d);
        chk("aux read", d, 8'h20);
        smp(1'b1, 16'h0150);
        settle();
        chk("sat pin", irq_pin, 1'b0);
        host_u.wr(OFS_CLR_CHAN, 8'h00);
        settle();
        chk("sat clear", {sflag, irq_pin}, 2'b01);
        smp(1'b1, 16'h0150);
        host_u.wr(OFS_CLR_ALL, 8'h00);
        settle();
        chk("sat clear all", {sflag, irq_pin}, 2'b01);
        smp(1'b1, 16'h0150);
        cen <= 1'b0;
        settle();
        chk("sat disable", sflag, 1'b0);
        smp(1'b1, 16'hFFFF);
        settle();
        chk("sat ignored", {sflag, tflag}, 2'b00);
        host_u.wr(OFS_CLR_ALL, 8'h00);
        cen <= 1'b1;
        $display("test saturation done");
    endtask

    // forced interrupt survives the channel clear
    task automatic t_force();
        host_u.wr(OFS_FORCE, 8'h00);
        settle();
        chk("force", irq_pin, 1'b0);
        chk("drain level", irq_o, 1'b0);
        host_u.wr(OFS_CLR_CHAN, 8'h00);
        settle();
        chk("force kept", irq_pin, 1'b0);
        host_u.wr(OFS_CLR_ALL, 8'h00);
        settle();
        chk("force clear", irq_pin, 1'b1);
        $display("test force done");
    endtask

    // one wait run, length checked against the expected cycle count
    task automatic wt(input logic [7:0] per, input logic wl, input int cyc);
        int n;
        n = 0;
        host_u.cfg(wl);
        @(posedge ref_clk);
        wper   <= per;
        wstart <= 1'b1;
        @(posedge ref_clk);
        wstart <= 1'b0;
        #1;
        chk("wait busy", wbusy, 1'b1);
        while (wdone !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("wait length", 16'(n >= cyc - 1 && n <= cyc + 2), 1'b1);
    endtask

    // wait timer short and long
    task automatic t_wait();
        wt(8'hFF, 1'b0, 4);
        wt(8'hFE, 1'b0, 8);
        wt(8'hFF, 1'b1, 48);
        host_u.rd(OFS_CONFIG, d);
        chk("config long", d, 8'h42);
        host_u.cfg(1'b0);
        $display("test wait done");
    endtask

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_gain();
        t_window();
        t_codes();
        t_sat();
        t_force();
        t_wait();
        stop_test();
    end

    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        stop_test();
    end
endmodule
